// ===== hdl/nand_device_info_readout.sv
// nand device information readout: id, signature, identifier, parameter page
// assumes nand pins already synchronous to aclk, axi4-lite for own registers
//
// Functional notes
// - fourth id byte bits 1:0 give page size
// - fourth id byte bit 2 gives spare size
// - fourth id byte bits 5:4 give block size
// - 90h then 20h returns four signature bytes
// - EDh returns identifier then its inverse
// - identifier pair repeats sixteen times
// - ECh returns page, repeated at least thrice
// - 05h-E0h moves output within the page
// - bytes 4-5 hold revision 02h 00h
// - bytes 6-7 hold features 10h or 11h
// - bytes 8-9 hold optional commands 33h
// - bytes 80-83 hold data bytes per page
// - bytes 92-95 hold pages per block
// - blocks per logical unit, one logical unit
// - byte 101 holds address cycles 22h
// - bytes 103-104 hold bad block maximum
// - byte 110 holds programs per page
// - byte 112 holds ecc correctability
// - byte 107 holds guaranteed good blocks
// - page check: poly 8005h, seed 4F4Eh
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module nand_device_info_readout #(
	parameter logic [7:0] MFR_CODE = 8'h00, // arbitrary value
	parameter logic [7:0] JEDEC_CODE = 8'h00 // arbitrary value
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe
);

	nand_info_pkg::state_t state_r;
	nand_info_pkg::mode_t mode_r;
	nand_info_pkg::mode_t pend_r;
	logic [15:0] ptr_r;
	logic col_hi_r;
	logic we_q_r;
	logic re_q_r;
	logic [6:0] cfg_r;
	logic [31:0] uid_r [0:3];
	logic aw_ok_r;
	logic w_ok_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic [7:0] io_out_r;
	logic crc_run_r;
	logic crc_ok_r;
	logic [7:0] crc_addr_r;
	logic [1:0] crc_key_r;
	logic crc_clr;
	logic [7:0] data_byte;
	logic [7:0] uid_byte;
	logic [7:0] dev_code;
	logic [7:0] id_b4;
	logic we_rise;
	logic rd_stb;
	logic cmd_stb;
	logic adr_stb;
	logic wr_fire;
	logic [1:0] cfg_key;

	ppage_if rd_pp ();
	ppage_if ck_pp ();

	// merges a bus write into a word under the byte strobes
	function automatic logic [31:0] merge_strb(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8 * i +: 8] = nw[8 * i +: 8];
		return r;
	endfunction : merge_strb

	// true for the identifier word offsets
	function automatic logic is_uid_reg(input logic [7:0] a);
		return a[7:4] == nand_info_pkg::REG_UID0[7:4] && a[1:0] == 2'b00;
	endfunction : is_uid_reg

	// pin edges; pins are already synchronous so no extra stages
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			we_q_r <= 1'b1;
			re_q_r <= 1'b1;
		end
		else
		begin
			we_q_r <= we_n;
			re_q_r <= re_n;
		end
	end

	assign we_rise = we_n && !we_q_r && !ce_n;
	assign cmd_stb = we_rise && cle && !ale;
	assign adr_stb = we_rise && ale && !cle;
	assign rd_stb = re_n && !re_q_r && !ce_n;

	// command, address and read sequencing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= nand_info_pkg::ST_IDLE;
			mode_r <= nand_info_pkg::MODE_NONE;
			pend_r <= nand_info_pkg::MODE_NONE;
			ptr_r <= 16'h0000;
			col_hi_r <= 1'b0;
		end
		else if (cmd_stb)
		begin
			case (io_in)
				nand_info_pkg::CMD_ID:
				begin
					state_r <= nand_info_pkg::ST_ADDR;
					pend_r <= nand_info_pkg::MODE_ID;
				end
				nand_info_pkg::CMD_UID:
				begin
					state_r <= nand_info_pkg::ST_ADDR;
					pend_r <= nand_info_pkg::MODE_UID;
				end
				nand_info_pkg::CMD_PAGE:
				begin
					state_r <= nand_info_pkg::ST_ADDR;
					pend_r <= nand_info_pkg::MODE_PAGE;
				end
				nand_info_pkg::CMD_RCOL:
				begin
					// repositioning only means something while a read is open
					if (mode_r != nand_info_pkg::MODE_NONE)
						state_r <= nand_info_pkg::ST_COL;
					col_hi_r <= 1'b0;
				end
				nand_info_pkg::CMD_RCONF:
				begin
					if (state_r == nand_info_pkg::ST_COL)
						state_r <= nand_info_pkg::ST_OUT;
				end
				nand_info_pkg::CMD_STAT:
					state_r <= nand_info_pkg::ST_STAT;
				nand_info_pkg::CMD_READ:
					// resume at the kept pointer after a status poll
					state_r <= (mode_r != nand_info_pkg::MODE_NONE) ?
						nand_info_pkg::ST_OUT : nand_info_pkg::ST_IDLE;
				default:
				begin
					// reset and every command outside this block end the read
					state_r <= nand_info_pkg::ST_IDLE;
					mode_r <= nand_info_pkg::MODE_NONE;
				end
			endcase
		end
		else if (adr_stb && state_r == nand_info_pkg::ST_ADDR)
		begin
			ptr_r <= 16'h0000;
			state_r <= nand_info_pkg::ST_OUT;
			if (pend_r != nand_info_pkg::MODE_ID)
				mode_r <= pend_r;
			else if (io_in == nand_info_pkg::ADR_SIG)
				mode_r <= nand_info_pkg::MODE_SIG;
			else if (io_in == nand_info_pkg::ADR_ID)
				mode_r <= nand_info_pkg::MODE_ID;
			else
				mode_r <= nand_info_pkg::MODE_NONE;
		end
		else if (adr_stb && state_r == nand_info_pkg::ST_COL)
		begin
			// two column cycles, low byte first
			if (col_hi_r)
				ptr_r[15:8] <= io_in;
			else
				ptr_r[7:0] <= io_in;
			col_hi_r <= 1'b1;
		end
		else if (rd_stb && state_r == nand_info_pkg::ST_OUT)
			ptr_r <= ptr_r + 16'h0001;
	end

	// identification bytes follow the configuration register
	assign id_b4 = {1'b0, cfg_r};
	assign cfg_key = {cfg_r[nand_info_pkg::CFG_WIDE_BIT], cfg_r[nand_info_pkg::CFG_FAST_BIT]};

	always_comb
	begin
		unique case (cfg_key)
			2'b01: dev_code = {nand_info_pkg::DEV_FAST_X8, nand_info_pkg::DEV_DENSITY};
			2'b11: dev_code = {nand_info_pkg::DEV_FAST_X16, nand_info_pkg::DEV_DENSITY};
			2'b00: dev_code = {nand_info_pkg::DEV_SLOW_X8, nand_info_pkg::DEV_DENSITY};
			2'b10: dev_code = {nand_info_pkg::DEV_SLOW_X16, nand_info_pkg::DEV_DENSITY};
		endcase
	end

	// identifier byte, inverted in the second half of each 32-byte span
	always_comb
	begin
		uid_byte = uid_r[ptr_r[3:2]][{ptr_r[1:0], 3'b000} +: 8];
		if (ptr_r[4])
			uid_byte = ~uid_byte;
		if (ptr_r >= nand_info_pkg::UID_SPAN)
			uid_byte = 8'h00;
	end

	// byte under the pointer for the open read
	always_comb
	begin
		data_byte = 8'h00;
		unique case (mode_r)
			nand_info_pkg::MODE_ID:
			begin
				if (ptr_r < nand_info_pkg::ID_LEN)
				begin
					unique case (ptr_r[2:0])
						3'h0: data_byte = MFR_CODE;
						3'h1: data_byte = dev_code;
						3'h2: data_byte = nand_info_pkg::ID_B3;
						3'h3: data_byte = id_b4;
						default: data_byte = nand_info_pkg::ID_B5;
					endcase
				end
			end
			nand_info_pkg::MODE_SIG:
			begin
				// past the fourth byte the value is left at zero
				if (ptr_r < nand_info_pkg::SIG_LEN)
					data_byte = nand_info_pkg::PP_TABLE[ptr_r[7:0]];
			end
			nand_info_pkg::MODE_UID:
				data_byte = uid_byte;
			nand_info_pkg::MODE_PAGE:
			begin
				// page repeats every 256 bytes without end
				if (ptr_r[7:0] == nand_info_pkg::PP_CRC_LO)
					data_byte = ck_pp.crc[7:0];
				else if (ptr_r[7:0] == nand_info_pkg::PP_CRC_HI)
					data_byte = ck_pp.crc[15:8];
				else
					data_byte = rd_pp.data;
			end
			default: data_byte = 8'h00;
		endcase
	end

	// output byte from a flop, one cycle behind the pointer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			io_out_r <= 8'h00;
		else if (state_r == nand_info_pkg::ST_STAT)
			io_out_r <= crc_run_r ? nand_info_pkg::STATUS_BUSY : nand_info_pkg::STATUS_RDY;
		else
			io_out_r <= data_byte;
	end

	assign io_out = io_out_r;
	assign io_oe = !ce_n && !re_n &&
		(state_r == nand_info_pkg::ST_OUT || state_r == nand_info_pkg::ST_STAT);

	// reader port of the page table
	assign rd_pp.addr = ptr_r[7:0];
	assign rd_pp.wide = cfg_r[nand_info_pkg::CFG_WIDE_BIT];
	assign rd_pp.fast = cfg_r[nand_info_pkg::CFG_FAST_BIT];
	assign rd_pp.clr = 1'b0;
	assign rd_pp.step = 1'b0;

	param_page_rom #(.JEDEC_CODE(JEDEC_CODE)) u_rd_rom (.pp(rd_pp));

	// check walk over bytes 0..253, rerun whenever width or speed changes;
	// a second table port keeps reads undisturbed, at the cost of area
	assign crc_clr = !crc_run_r && (!crc_ok_r || cfg_key != crc_key_r);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			crc_run_r <= 1'b0;
			crc_ok_r <= 1'b0;
			crc_addr_r <= 8'h00;
			crc_key_r <= 2'b00;
		end
		else if (crc_clr)
		begin
			crc_run_r <= 1'b1;
			crc_ok_r <= 1'b0;
			crc_addr_r <= 8'h00;
			crc_key_r <= cfg_key;
		end
		else if (crc_run_r)
		begin
			crc_addr_r <= crc_addr_r + 8'h01;
			if (crc_addr_r == nand_info_pkg::PP_LAST)
			begin
				crc_run_r <= 1'b0;
				crc_ok_r <= 1'b1;
			end
		end
	end

	assign ck_pp.addr = crc_addr_r;
	assign ck_pp.wide = crc_key_r[1];
	assign ck_pp.fast = crc_key_r[0];
	assign ck_pp.clr = crc_clr;
	assign ck_pp.step = crc_run_r;

	param_page_rom #(.JEDEC_CODE(JEDEC_CODE)) u_ck_rom (.pp(ck_pp));
	page_crc16 u_crc (.aclk(aclk), .aresetn(aresetn), .pp(ck_pp));

	// write address and data are taken independently, then applied together
	assign awready = !aw_ok_r;
	assign wready = !w_ok_r;
	assign wr_fire = aw_ok_r && w_ok_r && !bvalid_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_ok_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			else if (wr_fire)
				aw_ok_r <= 1'b0;
			if (wvalid && wready)
			begin
				w_ok_r <= 1'b1;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			else if (wr_fire)
				w_ok_r <= 1'b0;
		end
	end

	// config register steers the id bytes and the page fields
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cfg_r <= nand_info_pkg::CFG_RST;
		else if (wr_fire && awaddr_r == nand_info_pkg::REG_CFG)
			cfg_r <= 7'(merge_strb({25'h0, cfg_r}, wdata_r, wstrb_r));
	end

	// identifier words, byte 0 in the low lane of word 0
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_uid
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					uid_r[gi] <= nand_info_pkg::UID_RST;
				else if (wr_fire && is_uid_reg(awaddr_r) && awaddr_r[3:2] == 2'(gi))
					uid_r[gi] <= merge_strb(uid_r[gi], wdata_r, wstrb_r);
			end
		end
	endgenerate

	// write response; read-only and unmapped offsets answer slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= nand_info_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= (awaddr_r == nand_info_pkg::REG_CFG || is_uid_reg(awaddr_r)) ?
				nand_info_pkg::RESP_OKAY : nand_info_pkg::RESP_SLVERR;
		end
		else if (bready)
			bvalid_r <= 1'b0;
	end

	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	// read channel, one answer at a time
	assign arready = !rvalid_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= nand_info_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else if (arvalid && arready)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= nand_info_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			if (araddr == nand_info_pkg::REG_CFG)
				rdata_r <= {25'h0, cfg_r};
			else if (araddr == nand_info_pkg::REG_STAT)
				rdata_r <= {22'h0, crc_run_r, crc_ok_r, mode_r, state_r};
			else if (araddr == nand_info_pkg::REG_PTR)
				rdata_r <= {ck_pp.crc, ptr_r};
			else if (is_uid_reg(araddr))
				rdata_r <= uid_r[araddr[3:2]];
			else
				rresp_r <= nand_info_pkg::RESP_SLVERR;
		end
		else if (rready)
			rvalid_r <= 1'b0;
	end

	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;

endmodule : nand_device_info_readout

// ===== hdl/page_crc16.sv
// 16-bit check accumulator, msb first, one byte per step
// assumes clr and step never occur together
`timescale 1ns/1ps
module page_crc16 (
	input wire logic aclk,
	input wire logic aresetn,
	ppage_if.acc pp
);

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++)
			r = r[15] ? ({r[14:0], 1'b0} ^ nand_info_pkg::CRC_POLY) : {r[14:0], 1'b0};
		return r;
	endfunction : crc_byte

	// no final inversion and no reflection of data or result
	always_ff @(posedge aclk)
	begin
		if (!aresetn || pp.clr)
			pp.crc <= nand_info_pkg::CRC_SEED;
		else if (pp.step)
			pp.crc <= crc_byte(pp.crc, pp.data);
	end

endmodule : page_crc16

// ===== hdl/param_page_rom.sv
// parameter page contents for bytes 0 to 253, bytes 254 and 255 read zero
// assumes the controller inserts the check value itself
`timescale 1ns/1ps
module param_page_rom #(
	parameter logic [7:0] JEDEC_CODE = 8'h00 // arbitrary value
) (
	ppage_if.rom pp
);

	// fixed table, then the fields that follow the configuration
	always_comb
	begin
		pp.data = nand_info_pkg::PP_TABLE[pp.addr];
		if (pp.addr >= nand_info_pkg::PP_TEXT_LO && pp.addr <= nand_info_pkg::PP_TEXT_HI)
			pp.data = nand_info_pkg::TEXT_FILL; // blank text, arbitrary
		if (pp.addr == nand_info_pkg::PP_JEDEC)
			pp.data = JEDEC_CODE;
		if (pp.addr == nand_info_pkg::PP_FEAT)
			pp.data[0] = pp.wide;
		if (pp.addr == nand_info_pkg::PP_TM || pp.addr == nand_info_pkg::PP_TMC)
			pp.data = pp.fast ? nand_info_pkg::TM_FAST : nand_info_pkg::TM_SLOW;
	end

endmodule : param_page_rom

// ===== shared/nand_info_pkg.sv
// constants, field layouts and types for the nand device information readout
// assumes byte-wide command, address and data on the shared i/o lines
package nand_info_pkg;

	// command and address codes seen on the i/o lines
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_UID = 8'hed;
	localparam logic [7:0] CMD_PAGE = 8'hec;
	localparam logic [7:0] CMD_RCOL = 8'h05;
	localparam logic [7:0] CMD_RCONF = 8'he0;
	localparam logic [7:0] CMD_STAT = 8'h70;
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] ADR_ID = 8'h00;
	localparam logic [7:0] ADR_SIG = 8'h20;

	// signature characters, also the first bytes of the parameter page
	localparam logic [7:0] SIG_B0 = 8'h4f;
	localparam logic [7:0] SIG_B1 = 8'h4e;
	localparam logic [7:0] SIG_B2 = 8'h46;
	localparam logic [7:0] SIG_B3 = 8'h49;

	// identification bytes, device code nibbles and status bytes
	localparam logic [7:0] ID_B3 = 8'h80;
	localparam logic [7:0] ID_B5 = 8'h42;
	localparam logic [3:0] DEV_FAST_X8 = 4'hf;
	localparam logic [3:0] DEV_FAST_X16 = 4'hc;
	localparam logic [3:0] DEV_SLOW_X8 = 4'ha;
	localparam logic [3:0] DEV_SLOW_X16 = 4'hb;
	localparam logic [3:0] DEV_DENSITY = 4'h1;
	localparam logic [7:0] STATUS_RDY = 8'he0;
	localparam logic [7:0] STATUS_BUSY = 8'h80;

	// fourth id byte fields, mirrored by the config register
	localparam int CFG_PAGE_LSB = 0;
	localparam int CFG_SPARE_BIT = 2;
	localparam int CFG_FAST_BIT = 3;
	localparam int CFG_BLK_LSB = 4;
	localparam int CFG_WIDE_BIT = 6;
	localparam logic [6:0] CFG_RST = 7'h1d;

	// response lengths
	localparam logic [15:0] ID_LEN = 16'h0005;
	localparam logic [15:0] SIG_LEN = 16'h0004;
	localparam logic [15:0] UID_SPAN = 16'h0200;

	// parameter page layout and integrity check
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_SEED = 16'h4f4e;
	localparam logic [7:0] PP_FEAT = 8'h06;
	localparam logic [7:0] PP_TEXT_LO = 8'h20;
	localparam logic [7:0] PP_TEXT_HI = 8'h3f;
	localparam logic [7:0] PP_JEDEC = 8'h40;
	localparam logic [7:0] PP_TM = 8'h81;
	localparam logic [7:0] PP_TMC = 8'h83;
	localparam logic [7:0] PP_LAST = 8'hfd;
	localparam logic [7:0] PP_CRC_LO = 8'hfe;
	localparam logic [7:0] PP_CRC_HI = 8'hff;
	localparam logic [7:0] TM_FAST = 8'h07;
	localparam logic [7:0] TM_SLOW = 8'h03;
	localparam logic [7:0] TEXT_FILL = 8'h20;
	localparam logic [7:0] PP_TABLE [0:255] = '{
		0: SIG_B0, 1: SIG_B1, 2: SIG_B2, 3: SIG_B3,
		4: 8'h02, 6: 8'h10, 8: 8'h33,
		81: 8'h08, 84: 8'h80, 87: 8'h02, 90: 8'h20, 92: 8'h40,
		97: 8'h04, 100: 8'h01, 101: 8'h22, 102: 8'h01, 103: 8'h14,
		105: 8'h01, 106: 8'h05, 107: 8'h01, 108: 8'h01, 109: 8'h05,
		110: 8'h04, 112: 8'h04, 128: 8'h06,
		133: 8'hbc, 134: 8'h02, 135: 8'h10, 136: 8'h27, 137: 8'h19,
		139: 8'h3c, default: 8'h00};

	// register map and bus answers
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_PTR = 8'h08;
	localparam logic [7:0] REG_UID0 = 8'h10;
	localparam logic [31:0] UID_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		MODE_NONE = 3'h0,
		MODE_ID = 3'h1,
		MODE_SIG = 3'h2,
		MODE_UID = 3'h3,
		MODE_PAGE = 3'h4
	} mode_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_OUT = 5'h04,
		ST_COL = 5'h08,
		ST_STAT = 5'h10
	} state_t;

endpackage : nand_info_pkg

// ===== shared/ppage_if.sv
// one parameter page port: byte lookup plus optional check accumulation
// assumes a single controlling module drives address, options and steps
`timescale 1ns/1ps
interface ppage_if;
	logic [7:0] addr;
	logic wide;
	logic fast;
	logic [7:0] data;
	logic clr;
	logic step;
	logic [15:0] crc;

	modport ctl(output addr, output wide, output fast, output clr, output step,
		input data, input crc);
	modport rom(input addr, input wide, input fast, output data);
	modport acc(input data, input clr, input step, output crc);
endinterface : ppage_if

// ===== verif/nand_host_model.sv
// host controller model on the command, address and data pins
// assumes the device samples all pins on aclk and latches on we_n rising
`timescale 1ns/1ps
module nand_host_model (
	input wire logic aclk,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	output logic ce_n = 1'b1,
	output logic cle = 1'b0,
	output logic ale = 1'b0,
	output logic we_n = 1'b1,
	output logic re_n = 1'b1,
	output logic [7:0] io_in = 8'h00
);
	int slow = 0; // extra strobe cycles, for a sluggish host
	// one latch cycle; byte and enables held to the edge after we_n rises
	task automatic wr(input logic c, input logic [7:0] v);
		@(posedge aclk);
		ce_n <= 1'b0;
		cle <= c;
		ale <= !c;
		io_in <= v;
		we_n <= 1'b0;
		@(posedge aclk);
		we_n <= 1'b1;
		@(posedge aclk);
		cle <= 1'b0;
		ale <= 1'b0;
		io_in <= ~v; // released lines never echo the old byte
	endtask : wr
	// strobe held low past the two-cycle output delay; undriven bus reads unknown
	task automatic rd(output logic [7:0] b);
		@(posedge aclk);
		re_n <= 1'b0;
		repeat (2 + slow) @(posedge aclk);
		@(negedge aclk);
		b = io_oe ? io_out : 8'hxx;
		@(posedge aclk);
		re_n <= 1'b1;
	endtask : rd
endmodule : nand_host_model

// ===== verif/nand_info_properties.sv
// timing checks on the ports of the nand device information readout
// assumes a bind onto the top module, one clock, synchronous low reset
`timescale 1ns/1ps
module nand_info_properties #(
	parameter logic [7:0] MFR_CODE = 8'h00
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic [7:0] io_in,
	input wire logic [7:0] io_out,
	input wire logic io_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic we_prev_r;
	logic [7:0] cmd_r;
	logic we_up;
	logic adr_up;
	// latch seen on the we_n rise, as the device samples it
	assign we_up = we_n && !we_prev_r && !ce_n;
	assign adr_up = we_up && ale && !cle;
	// last command, so address cycles can be judged by what opened them
	always_ff @(posedge aclk)
	begin
		we_prev_r <= we_n;
		if (!aresetn)
			cmd_r <= 8'h00;
		else if (we_up && cle && !ale)
			cmd_r <= io_in;
	end
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rresp))
		else $error("read answer dropped early");
	a_ar_gate: assert property (arready == !rvalid)
		else $error("arready not tied to free read slot");
	a_rd_cfg: assert property (arvalid && arready && araddr == 8'h00 |=> rvalid && rresp == 2'h0)
		else $error("config read not answered okay");
	a_rd_hole: assert property (arvalid && arready && araddr == 8'h40 |=> rvalid && rresp == 2'h2)
		else $error("unmapped read not refused");
	a_oe_gate: assert property (io_oe |-> !ce_n && !re_n)
		else $error("io driven outside a read strobe");
	a_id_first: assert property (adr_up && cmd_r == 8'h90 && io_in == 8'h00 |-> ##2 io_out == MFR_CODE)
		else $error("id read does not start with maker byte");
	a_sig_first: assert property (adr_up && cmd_r == 8'h90 && io_in == 8'h20 |-> ##2 io_out == 8'h4f)
		else $error("signature does not start with 4f");
	a_page_first: assert property (adr_up && cmd_r == 8'hec |-> ##2 io_out == 8'h4f)
		else $error("page read does not start with 4f");
	a_stat_byte: assert property (we_up && cle && !ale && io_in == 8'h70
		|-> ##2 (io_out == 8'he0 || io_out == 8'h80))
		else $error("status byte not presented");
endmodule : nand_info_properties

// ===== verif/tb_nand_device_info_readout.sv
// self-checking bench for the nand device information readout
// assumes the host model drives the nand pins and this module the register bus
`timescale 1ns/1ps
module tb_nand_device_info_readout;
	// nonzero page bytes outside the text field, index in the upper byte
	localparam logic [15:0] PV [33] = '{16'h004f, 16'h014e, 16'h0246, 16'h0349, 16'h0402,
		16'h0610, 16'h0833, 16'h5108, 16'h5480, 16'h5702, 16'h5a20, 16'h5c40, 16'h6104,
		16'h6401, 16'h6522, 16'h6601, 16'h6714, 16'h6901, 16'h6a05, 16'h6b01, 16'h6c01,
		16'h6d05, 16'h6e04, 16'h7004, 16'h8006, 16'h8107, 16'h8307, 16'h85bc, 16'h8602,
		16'h8710, 16'h8827, 16'h8919, 16'h8b3c};
	localparam logic [6:0] CF [4] = '{7'h15, 7'h2a, 7'h44, 7'h7b};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, ce_n, cle, ale, we_n, re_n, io_oe;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, q;
	logic [7:0] io_in, io_out, b;
	logic [7:0] e [256];
	logic [7:0] u [64];
	logic [39:0] idw;
	logic [15:0] crc;
	int mismatches = 0;
	int num_checks = 0;
	always #4 aclk = ~aclk;
	nand_device_info_readout uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe));
	nand_host_model host (.aclk(aclk), .io_out(io_out), .io_oe(io_oe), .ce_n(ce_n),
		.cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .io_in(io_in));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	function automatic logic [7:0] idb(input int n);
		return 8'(n * 29 + 53);
	endfunction : idb
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] x;
		x = c ^ {d, 8'h00};
		repeat (8) x = x[15] ? ((x << 1) ^ 16'h8005) : (x << 1);
		return x;
	endfunction : crc_upd
	// one register access; ready and answer are sampled mid-cycle, acted on at the edge
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic [1:0] rp);
		logic ta, tw, te;
		@(posedge aclk);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= wr;
		wvalid <= wr;
		bready <= wr;
		arvalid <= !wr;
		rready <= !wr;
		do
		begin
			@(negedge aclk);
			ta = wr ? awready : arready;
			tw = wready;
			te = wr ? bvalid : rvalid;
			rd = rdata;
			rp = wr ? bresp : rresp;
			@(posedge aclk);
			if (ta)
			begin
				awvalid <= 1'b0;
				arvalid <= 1'b0;
			end
			if (tw)
				wvalid <= 1'b0;
		end while (!te);
		bready <= 1'b0;
		rready <= 1'b0;
	endtask : axi
	task automatic op(input logic [7:0] c, input logic [7:0] a);
		host.wr(1'b1, c);
		host.wr(1'b0, a);
	endtask : op
	task automatic col(input logic [15:0] c);
		op(8'h05, c[7:0]);
		host.wr(1'b0, c[15:8]);
		host.wr(1'b1, 8'he0);
	endtask : col
	// status poll then 00h, host must reissue read before more data
	task automatic poll(input logic [7:0] exp);
		host.wr(1'b1, 8'h70);
		host.rd(b);
		check("status", b, 8'he0);
		host.wr(1'b1, 8'h00);
		host.rd(b);
		check("resume", b, exp);
	endtask : poll
	task automatic t_regs;
		axi(1'b0, 8'h00, 32'h0, q, rs);
		check("cfg reset", q[6:0], 7'h1d);
		axi(1'b1, 8'h40, 32'h0000_00ff, q, rs);
		check("hole write", rs, 2'h2);
		axi(1'b0, 8'h40, 32'h0, q, rs);
		check("hole read", rs, 2'h2);
		axi(1'b1, 8'h04, 32'h0, q, rs);
		check("stat write", rs, 2'h2);
		q = 32'h0;
		// check bytes are only trusted once the walk has finished
		for (int i = 0; i < 100 && !q[8]; i++) axi(1'b0, 8'h04, 32'h0, q, rs);
		check("crc ready", q[8], 1'b1);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_page;
		foreach (e[i]) e[i] = (i >= 32 && i < 64) ? 8'h20 : 8'h00;
		foreach (PV[i]) e[PV[i][15:8]] = PV[i][7:0];
		crc = 16'h4f4e;
		for (int i = 0; i < 254; i++) crc = crc_upd(crc, e[i]);
		e[254] = crc[7:0];
		e[255] = crc[15:8];
		op(8'hec, 8'h00);
		for (int i = 0; i < 256; i++)
		begin
			host.rd(b);
			check("page", b, e[i]);
		end
		col(16'h0203);
		host.rd(b);
		check("third copy", b, 8'h49);
		poll(8'h02);
		axi(1'b1, 8'h00, 32'h0000_005d, q, rs);
		col(16'h0006);
		host.rd(b);
		check("wide feature", b, 8'h11);
		$display("t_page done");
	endtask : t_page
	task automatic t_sig;
		op(8'h90, 8'h20);
		// only four bytes are read, what follows is undefined
		for (int i = 0; i < 4; i++)
		begin
			host.rd(b);
			check("signature", b, 8'(32'h4f4e4649 >> (8 * (3 - i))));
		end
		$display("t_sig done");
	endtask : t_sig
	task automatic t_uid;
		for (int k = 0; k < 4; k++)
			axi(1'b1, 8'(16 + 4 * k), {idb(4*k+3), idb(4*k+2), idb(4*k+1), idb(4*k)}, q, rs);
		host.slow = 2;
		op(8'hed, 8'h00);
		for (int i = 0; i < 64; i++)
		begin
			host.rd(u[i]);
			check("identifier", u[i], i % 32 < 16 ? idb(i % 32) : ~idb(i % 32 - 16));
		end
		for (int k = 0; k < 16; k++) check("pair xor", u[k] ^ u[k + 16], 8'hff);
		col(16'h01f0);
		host.rd(b);
		check("far copy", b, ~idb(0));
		poll(~idb(1));
		host.slow = 0;
		$display("t_uid done");
	endtask : t_uid
	task automatic t_id;
		foreach (CF[i])
		begin
			axi(1'b1, 8'h00, {25'h0, CF[i]}, q, rs);
			axi(1'b0, 8'h00, 32'h0, q, rs);
			check("cfg", q[6:0], CF[i]);
			idw = {8'h42, 1'b0, CF[i], 8'h80, CF[i][6] ? (CF[i][3] ? 8'hc1 : 8'hb1)
				: (CF[i][3] ? 8'hf1 : 8'ha1), 8'h00};
			op(8'h90, 8'h00);
			for (int j = 0; j < 5; j++)
			begin
				host.rd(b);
				check("id byte", b, idw[8*j +: 8]);
			end
		end
		$display("t_id done");
	endtask : t_id
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_page();
		t_sig();
		t_uid();
		t_id();
		test_done();
	end
	// the run needs well under ten thousand cycles
	initial
	begin
		repeat (40000) @(posedge aclk);
		mismatches++;
		test_done();
	end
endmodule : tb_nand_device_info_readout
bind nand_device_info_readout nand_info_properties #(.MFR_CODE(MFR_CODE)) chk (.aclk(aclk),
	.aresetn(aresetn), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rresp(rresp),
	.rvalid(rvalid), .rready(rready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .io_in(io_in),
	.io_out(io_out), .io_oe(io_oe));
